/* core/dpr_host.sv */
// What this block does
// - write strobe stays high during every read
// - reads always select-framed, never address-controlled
// - address settles before selects fall
// - ram or flag select combination held stable
// - upper byte access uses only upper lane
// - address changes only while strobe high
// - recovery counted before address changes
// - output enable high, so no stretch
// - minimum write pulse used with enable high
// - write data held past strobe rise
// - never drive data while port drives
// - wait gap after flag write before read
`timescale 1ns/1ns
module dpr_host
  import dpr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire dpr_req_t req,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_data,
  output dpr_pins_t pins,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe
);

  typedef enum logic [2:0] {
    DPR_IDLE = 3'b000,
    DPR_RD_ADDR = 3'b001,
    DPR_RD_ACT = 3'b010,
    DPR_WR_ADDR = 3'b011,
    DPR_WR_PULSE = 3'b100,
    DPR_WR_HOLD = 3'b101,
    DPR_RECOV = 3'b110
  } dpr_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // data pin synchroniser

  logic [DATA_W-1:0] sync1_reg;
  logic [DATA_W-1:0] sync2_reg;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sync1_reg <= DATA_RESET;
      sync2_reg <= DATA_RESET;
    end
    else
    begin
      sync1_reg <= data_in;
      sync2_reg <= sync1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cycle timer

  logic tload;
  logic [TIMER_W-1:0] tval;
  logic tdone;

  dpr_timer u_dpr_timer (
    .clock(clock),
    .rst(rst),
    .load(tload),
    .load_value(tval),
    .done(tdone)
  );

  ////////////////////////////////////////////////////////////////////////////
  // cycle sequencer

  dpr_state_t state_reg;
  dpr_state_t state_next;
  dpr_req_t hold_reg;
  dpr_req_t hold_next;
  dpr_pins_t pins_reg;
  dpr_pins_t pins_next;
  logic [DATA_W-1:0] dout_reg;
  logic [DATA_W-1:0] dout_next;
  logic doe_reg;
  logic doe_next;
  logic rsp_valid_reg;
  logic rsp_valid_next;
  logic [DATA_W-1:0] rsp_data_reg;
  logic [DATA_W-1:0] rsp_data_next;
  logic [1:0] lanes;
  logic [DATA_W-1:0] lane_mask;

  // an empty byte enable on a ram access means the whole word
  assign lanes = (hold_reg.byte_en == 2'b00) ? 2'b11 : hold_reg.byte_en;
  assign lane_mask = {{8{lanes[1]}}, {8{lanes[0]}}};

  always_comb
  begin
    state_next = state_reg;
    hold_next = hold_reg;
    pins_next = pins_reg;
    dout_next = dout_reg;
    doe_next = doe_reg;
    rsp_valid_next = 1'b0;
    rsp_data_next = rsp_data_reg;
    tload = 1'b0;
    tval = '0;
    case (state_reg)
      DPR_IDLE:
      begin
        if (req_valid)
        begin
          hold_next = req;
          pins_next = PINS_IDLE;
          pins_next.addr = req.addr;
          state_next = req.write ? DPR_WR_ADDR : DPR_RD_ADDR;
        end
      end
      DPR_RD_ADDR:
      begin
        // selects fall one cycle after the address is stable
        pins_next.port_select_n = hold_reg.flag;
        pins_next.flag_port_select_n = ~hold_reg.flag;
        pins_next.upper_byte_select_n = hold_reg.flag | ~lanes[1];
        pins_next.lower_byte_select_n = hold_reg.flag | ~lanes[0];
        pins_next.write_strobe_n = 1'b1;
        pins_next.output_enable_n = 1'b0;
        tload = 1'b1;
        tval = TIMER_W'(READ_CYC);
        state_next = DPR_RD_ACT;
      end
      DPR_RD_ACT:
      begin
        if (tdone)
        begin
          rsp_valid_next = 1'b1;
          rsp_data_next = hold_reg.flag ? sync2_reg : (sync2_reg & lane_mask);
          pins_next = PINS_IDLE;
          pins_next.addr = hold_reg.addr;
          // let the port float its drivers before anything drives the bus
          tload = 1'b1;
          tval = TIMER_W'(FLOAT_CYC);
          state_next = DPR_RECOV;
        end
      end
      DPR_WR_ADDR:
      begin
        // output enable stays high so the pulse needs no stretch
        pins_next.output_enable_n = 1'b1;
        pins_next.port_select_n = hold_reg.flag;
        pins_next.flag_port_select_n = ~hold_reg.flag;
        pins_next.upper_byte_select_n = hold_reg.flag | ~lanes[1];
        pins_next.lower_byte_select_n = hold_reg.flag | ~lanes[0];
        pins_next.write_strobe_n = 1'b0;
        dout_next = hold_reg.wdata;
        doe_next = 1'b1;
        tload = 1'b1;
        tval = TIMER_W'(WRITE_CYC);
        state_next = DPR_WR_PULSE;
      end
      DPR_WR_PULSE:
      begin
        if (tdone)
        begin
          // strobe rises first and ends the write, selects follow
          pins_next.write_strobe_n = 1'b1;
          state_next = DPR_WR_HOLD;
        end
      end
      DPR_WR_HOLD:
      begin
        pins_next = PINS_IDLE;
        pins_next.addr = hold_reg.addr;
        doe_next = 1'b0;
        tload = 1'b1;
        tval = hold_reg.flag ? TIMER_W'(FLAG_GAP_CYC) : TIMER_W'(RECOVERY_CYC);
        state_next = DPR_RECOV;
      end
      DPR_RECOV:
      begin
        if (tdone)
        begin
          state_next = DPR_IDLE;
        end
      end
      default:
      begin
        state_next = DPR_IDLE;
        pins_next = PINS_IDLE;
        doe_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_reg <= DPR_IDLE;
      hold_reg <= '0;
      pins_reg <= PINS_IDLE;
      dout_reg <= DATA_RESET;
      doe_reg <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= DATA_RESET;
    end
    else
    begin
      state_reg <= state_next;
      hold_reg <= hold_next;
      pins_reg <= pins_next;
      dout_reg <= dout_next;
      doe_reg <= doe_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_data_reg <= rsp_data_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign req_ready = (state_reg == DPR_IDLE);
  assign rsp_valid = rsp_valid_reg;
  assign rsp_data = rsp_data_reg;
  assign pins = pins_reg;
  assign data_out = dout_reg;
  assign data_oe = doe_reg;

endmodule

/* core/dpr_pkg.sv */
package dpr_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int TIMER_W = 4;

  localparam int CLK_PERIOD_NS = 8;

  // slowest speed grade, so every grade of part is served
  localparam int READ_ACCESS_NS = 70;
  localparam int OUTPUT_FLOAT_NS = 30;
  localparam int SELECT_TO_WRITE_END_NS = 50;
  localparam int WRITE_PULSE_MIN_NS = 45;
  localparam int DATA_SETUP_TO_WRITE_END_NS = 40;
  localparam int WRITE_RECOVERY_NS = 0;
  localparam int FLAG_WRITE_TO_READ_GAP_NS = 10;
  localparam int FLAG_CONTENTION_WINDOW_NS = 10;
  localparam int SYNC_STAGES = 2;

  function automatic int dpr_cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int dpr_max3(input int a, input int b, input int c);
    int m;
    m = (a > b) ? a : b;
    return (m > c) ? m : c;
  endfunction

  localparam int READ_CYC = dpr_cyc_up(READ_ACCESS_NS) + SYNC_STAGES;
  localparam int FLOAT_CYC = dpr_cyc_up(OUTPUT_FLOAT_NS);
  localparam int WRITE_CYC = dpr_max3(dpr_cyc_up(SELECT_TO_WRITE_END_NS),
    dpr_cyc_up(WRITE_PULSE_MIN_NS), dpr_cyc_up(DATA_SETUP_TO_WRITE_END_NS));
  localparam int RECOVERY_CYC = dpr_cyc_up(WRITE_RECOVERY_NS);
  localparam int FLAG_GAP_CYC = dpr_cyc_up(FLAG_WRITE_TO_READ_GAP_NS);
  localparam int FLAG_WINDOW_CYC = dpr_cyc_up(FLAG_CONTENTION_WINDOW_NS);

  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;

  typedef struct packed {
    logic write;
    logic flag;
    logic [1:0] byte_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dpr_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic port_select_n;
    logic flag_port_select_n;
    logic upper_byte_select_n;
    logic lower_byte_select_n;
    logic write_strobe_n;
    logic output_enable_n;
  } dpr_pins_t;

  localparam dpr_pins_t PINS_IDLE = '{addr: ADDR_RESET, port_select_n: 1'b1,
    flag_port_select_n: 1'b1, upper_byte_select_n: 1'b1, lower_byte_select_n: 1'b1,
    write_strobe_n: 1'b1, output_enable_n: 1'b1};

endpackage

/* core/dpr_timer.sv */
`timescale 1ns/1ns
module dpr_timer
  import dpr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic load,
  input wire logic [TIMER_W-1:0] load_value,
  output logic done
);

  logic [TIMER_W-1:0] cnt_reg;
  logic [TIMER_W-1:0] cnt_next;

  always_comb
  begin
    cnt_next = cnt_reg;
    if (load)
    begin
      cnt_next = load_value;
    end
    else if (cnt_reg != '0)
    begin
      cnt_next = cnt_reg - 4'h1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cnt_reg <= '0;
    end
    else
    begin
      cnt_reg <= cnt_next;
    end
  end

  // a load of n keeps the caller in its state for n cycles
  assign done = (cnt_reg <= 4'h1);

endmodule

/* tb/dpr_host_checker.sv */
`timescale 1ns/1ns
module dpr_host_checker
  import dpr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire dpr_req_t req,
  input wire logic rsp_valid,
  input wire logic [DATA_W-1:0] rsp_data,
  input wire dpr_pins_t pins,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  read_strobe_high_a: assert property (!pins.output_enable_n |-> pins.write_strobe_n)
    else $error("strobe low during read");
  read_selected_a: assert property (!pins.output_enable_n |->
    !pins.port_select_n || !pins.flag_port_select_n) else $error("unframed read");
  read_latency_a: assert property (req_valid && req_ready && !req.write |-> ##13 rsp_valid)
    else $error("read answer late");
  addr_at_select_a: assert property ($fell(pins.port_select_n) ||
    $fell(pins.flag_port_select_n) |-> $stable(pins.addr)) else $error("addr moved at select");
  flag_select_a: assert property (!pins.flag_port_select_n |-> pins.port_select_n &&
    pins.upper_byte_select_n && pins.lower_byte_select_n) else $error("bad flag select");
  addr_hold_write_a: assert property (!pins.write_strobe_n |-> $stable(pins.addr))
    else $error("addr moved in write");
  write_pulse_a: assert property ($fell(pins.write_strobe_n) |->
    (!pins.write_strobe_n)[*7] ##1 pins.write_strobe_n) else $error("bad write pulse");
  data_hold_a: assert property ($rose(pins.write_strobe_n) |->
    data_oe && $stable(data_out)) else $error("data not held");
  flag_gap_a: assert property ($rose(pins.write_strobe_n) && !pins.flag_port_select_n |=>
    (pins.flag_port_select_n)[*2]) else $error("flag read too soon");
  no_drive_read_a: assert property (data_oe |-> pins.output_enable_n)
    else $error("drive during read");
  cover property (req_valid && req_ready && req.write && !req.flag);
  cover property (req_valid && req_ready && !req.write && !req.flag);
  cover property (req_valid && req_ready && req.flag);
  cover property (req_valid && req_ready && req.write && req.byte_en == 2'b10);
endmodule
bind dpr_host dpr_host_checker u_chk (.clock(clock), .rst(rst), .req_valid(req_valid),
  .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pins(pins),
  .data_in(data_in), .data_out(data_out), .data_oe(data_oe));

/* tb/dpr_ram_model.sv */
`timescale 1ns/1ns
module dpr_ram_model
  import dpr_pkg::*;
(
  input wire logic clock,
  input wire dpr_pins_t pins,
  input wire logic [DATA_W-1:0] data_out,
  output logic [DATA_W-1:0] data_in
);
  logic [DATA_W-1:0] mem [0:4095];
  logic [7:0] flag_reg = 8'hFF;
  logic [DATA_W-1:0] last = 16'h0000;
  logic ram_sel, flag_sel, rd;
  logic [DATA_W-1:0] lane, val;
  initial for (int i = 0; i < 4096; i++) mem[i] = 16'h0000;
  assign ram_sel = !pins.port_select_n && pins.flag_port_select_n;
  assign flag_sel = pins.port_select_n && !pins.flag_port_select_n;
  assign rd = pins.write_strobe_n && !pins.output_enable_n;
  assign lane = flag_sel ? 16'hFFFF :
    {{8{!pins.upper_byte_select_n}}, {8{!pins.lower_byte_select_n}}};
  assign val = flag_sel ? {16{flag_reg[pins.addr[2:0]]}} : mem[pins.addr];
  // released lanes show the inverse of their last level
  assign data_in = (rd && (ram_sel || flag_sel)) ? ((val & lane) | (~last & ~lane)) : ~last;
  always @(posedge clock)
  begin
    last <= data_in;
    if (!pins.write_strobe_n && ram_sel)
      mem[pins.addr] <= (data_out & lane) | (mem[pins.addr] & ~lane);
    if (!pins.write_strobe_n && flag_sel)
      flag_reg[pins.addr[2:0]] <= data_out[0];
  end
endmodule

/* tb/test_dual_port_ram_port_cycles.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module test_dual_port_ram_port_cycles;
  import dpr_pkg::*;
  logic clock, rst, req_valid, req_ready, rsp_valid, data_oe;
  dpr_req_t req;
  dpr_pins_t pins;
  logic [DATA_W-1:0] rsp_data, data_in, data_out, exp_v;
  logic [DATA_W-1:0] ref_mem [0:4095];
  logic [7:0] ref_flag = 8'hFF;
  logic [DATA_W-1:0] exp_q [$];
  logic [31:0] seed = 32'h71FD1550;
  int failures = 0;
  int cmp_count = 0;
  dpr_host u_dpr_host (.clock(clock), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pins(pins), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe));
  dpr_ram_model u_model (.clock(clock), .pins(pins), .data_out(data_out), .data_in(data_in));
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic finish_test();
    if (failures == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic do_req(input logic w, input logic f, input logic [1:0] be,
    input logic [11:0] a, input logic [15:0] d);
    int n;
    logic [1:0] eb;
    logic [15:0] m;
    n = 0;
    eb = (be == 2'h0) ? 2'h3 : be;
    m = {{8{eb[1]}}, {8{eb[0]}}};
    @(posedge clock);
    #1;
    while (req_ready !== 1'b1 && n < 100)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= 100)
    begin
      failures++;
      finish_test();
    end
    @(posedge clock);
    req_valid <= 1'b1;
    req <= '{write: w, flag: f, byte_en: be, addr: a, wdata: d};
    if (f && w)
      ref_flag[a[2:0]] = d[0];
    else if (f)
      exp_q.push_back({16{ref_flag[a[2:0]]}});
    else if (w)
      ref_mem[a] = (d & m) | (ref_mem[a] & ~m);
    else
      exp_q.push_back(ref_mem[a] & m);
    @(posedge clock);
    req_valid <= 1'b0;
  endtask
  always @(posedge clock)
    if (!rst && rsp_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        `CHK(rsp_valid, 1'b0)
      else
      begin
        exp_v = exp_q.pop_front();
        `CHK(rsp_data, exp_v)
      end
    end
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial
  begin
    logic [11:0] a;
    int n;
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    for (int i = 0; i < 4096; i++) ref_mem[i] = 16'h0000;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr_next(seed);
      a = seed[11:0];
      do_req(1'b1, 1'b0, 2'h3, a, seed[31:16]);
      seed = lfsr_next(seed);
      do_req(1'b1, 1'b0, i[1:0], a, seed[15:0]);
      do_req(1'b0, 1'b0, 2'(i + 1), a, 16'h0000);
      do_req(1'b0, 1'b0, 2'h3, a, 16'h0000);
    end
    for (int k = 0; k < 8; k++)
    begin
      seed = lfsr_next(seed);
      do_req(1'b0, 1'b1, 2'h0, 12'(k), 16'h0000);
      do_req(1'b1, 1'b1, 2'h0, 12'(k), seed[15:0]);
      do_req(1'b0, 1'b1, 2'h0, 12'(k), 16'h0000);
      do_req(1'b1, 1'b1, 2'h0, 12'(k), 16'h0001);
    end
    n = 0;
    while (exp_q.size() != 0 && n < 100)
    begin
      @(posedge clock);
      n++;
    end
    if (n >= 100)
      failures++;
    finish_test();
  end
endmodule
